/* File: rtl/fcsm_pkg.sv */
// Package with constants for the flash command host controller
package fcsm_pkg;
    // Register byte offsets
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_ADDR = 4'h4;
    localparam logic [3:0] REG_DATA = 4'h8;
    localparam logic [3:0] REG_STAT = 4'hC;
    // Control register fields
    localparam int CTRL_GO_LSB = 0;
    localparam int CTRL_OP_LSB = 1;
    localparam int CTRL_BYTE_BIT = 4;
    localparam int CTRL_UNPROT_BIT = 5;
    // Status register fields
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    localparam int STAT_FAIL_BIT = 2;
    localparam int STAT_RB_BIT = 3;
    // Operation codes
    localparam logic [2:0] OP_READ = 3'h0;
    localparam logic [2:0] OP_RESET = 3'h1;
    localparam logic [2:0] OP_PROGRAM = 3'h2;
    localparam logic [2:0] OP_CHIP_ERASE = 3'h3;
    localparam logic [2:0] OP_AUTOSEL = 3'h4;
    // Command sequence addresses and data
    localparam logic [19:0] UNLOCK1_ADDR_W = 20'h00555;
    localparam logic [19:0] UNLOCK2_ADDR_W = 20'h002AA;
    localparam logic [19:0] UNLOCK1_ADDR_B = 20'h00AAA;
    localparam logic [19:0] UNLOCK2_ADDR_B = 20'h00555;
    localparam logic [15:0] CMD_UNLOCK1 = 16'h00AA;
    localparam logic [15:0] CMD_UNLOCK2 = 16'h0055;
    localparam logic [15:0] CMD_AUTOSEL = 16'h0090;
    localparam logic [15:0] CMD_PROGRAM = 16'h00A0;
    localparam logic [15:0] CMD_ERASE = 16'h0080;
    localparam logic [15:0] CMD_CHIP_ERASE = 16'h0010;
    localparam logic [15:0] CMD_RESET = 16'h00F0;
    // Bus timing in ns and cycles at 100 MHz
    localparam int CLK_NS = 10;
    localparam int SETUP_NS = 20;
    localparam int PULSE_NS = 50;
    localparam int ACCESS_NS = 90;
    localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int PULSE_CYC = (PULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
    // Polls before the controller gives up
    localparam int POLL_LIMIT = 65535;
    localparam logic [2:0] ADDR_POLL_BIT = 3'h7;
    localparam int FAIL_FLAG_BIT = 5;
endpackage : fcsm_pkg

/* File: rtl/fcsm_cyc_if.sv */
// Interface between the sequencer and the bus cycle engine
`timescale 1ns/1ps
`default_nettype none
interface fcsm_cyc_if;
    logic req;
    logic wr;
    logic [19:0] addr;
    logic [15:0] wdata;
    logic done;
    logic [15:0] rdata;
    modport seq (output req, output wr, output addr, output wdata,
                 input done, input rdata);
    modport eng (input req, input wr, input addr, input wdata,
                 output done, output rdata);
endinterface : fcsm_cyc_if
`default_nettype wire

/* File: rtl/fcsm_cycle.sv */
// Flash bus cycle engine: one write pulse or one timed read
`timescale 1ns/1ps
`default_nettype none
module fcsm_cycle (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Request side
    fcsm_cyc_if.eng cyc,
    // Flash pins
    output logic [19:0] fl_addr,
    output logic [15:0] fl_dq_out,
    output logic fl_dq_oe,
    input wire logic [15:0] fl_dq_in,
    output logic fl_chip_select_n,
    output logic fl_write_strobe_n,
    output logic fl_output_enable_n
);
    typedef enum logic [3:0] {
        C_IDLE = 4'h1, C_SETUP = 4'h2, C_PULSE = 4'h4, C_HOLD = 4'h8
    } fcsm_cst_t;

    fcsm_cst_t st_r, st_nxt;
    logic [7:0] cnt_r, cnt_nxt;
    logic wr_r, wr_nxt;
    logic [19:0] addr_r, addr_nxt;
    logic [15:0] wd_r, wd_nxt;
    logic [15:0] rd_r, rd_nxt;
    logic [15:0] dq_s1_r, dq_s2_r;
    logic done_r, done_nxt;

    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        wr_nxt = wr_r;
        addr_nxt = addr_r;
        wd_nxt = wd_r;
        rd_nxt = rd_r;
        done_nxt = 1'b0;
        unique case (st_r)
            C_IDLE: begin
                if (cyc.req) begin
                    wr_nxt = cyc.wr;
                    addr_nxt = cyc.addr;
                    wd_nxt = cyc.wdata;
                    cnt_nxt = 8'(fcsm_pkg::SETUP_CYC);
                    st_nxt = C_SETUP;
                end
            end
            C_SETUP: begin
                // Address stable before the strobe falls
                if (cnt_r == 8'h01) begin
                    cnt_nxt = wr_r ? 8'(fcsm_pkg::PULSE_CYC)
                                   : 8'(fcsm_pkg::ACCESS_CYC + 2);
                    st_nxt = C_PULSE;
                end else begin
                    cnt_nxt = cnt_r - 8'h01;
                end
            end
            C_PULSE: begin
                // Reads wait two extra cycles for the pin synchroniser
                if (cnt_r == 8'h01) begin
                    rd_nxt = dq_s2_r;
                    cnt_nxt = 8'(fcsm_pkg::SETUP_CYC);
                    st_nxt = C_HOLD;
                end else begin
                    cnt_nxt = cnt_r - 8'h01;
                end
            end
            C_HOLD: begin
                if (cnt_r == 8'h01) begin
                    done_nxt = 1'b1;
                    st_nxt = C_IDLE;
                end else begin
                    cnt_nxt = cnt_r - 8'h01;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= C_IDLE;
            cnt_r <= 8'h00;
            wr_r <= 1'b0;
            addr_r <= 20'h00000;
            wd_r <= 16'h0000;
            rd_r <= 16'h0000;
            dq_s1_r <= 16'h0000;
            dq_s2_r <= 16'h0000;
            done_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            wr_r <= wr_nxt;
            addr_r <= addr_nxt;
            wd_r <= wd_nxt;
            rd_r <= rd_nxt;
            dq_s1_r <= fl_dq_in;
            dq_s2_r <= dq_s1_r;
            done_r <= done_nxt;
        end
    end

    // Write only with select and strobe low, output enable high
    // Address set before strobe falls, data held past its rise
    assign fl_chip_select_n = (st_r == C_IDLE);
    assign fl_write_strobe_n = !(wr_r && st_r == C_PULSE);
    assign fl_output_enable_n = !(!wr_r && st_r == C_PULSE);
    assign fl_addr = addr_r;
    assign fl_dq_out = wd_r;
    assign fl_dq_oe = wr_r && st_r != C_IDLE;
    assign cyc.done = done_r;
    assign cyc.rdata = rd_r;
endmodule : fcsm_cycle
`default_nettype wire

/* File: rtl/fcsm_host.sv */
// Host controller issuing command sequences to a NOR flash
`timescale 1ns/1ps
`default_nettype none
module fcsm_host (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Software register port
    input wire logic [3:0] sw_addr,
    input wire logic [31:0] sw_wdata,
    input wire logic sw_wr,
    input wire logic sw_rd,
    output logic [31:0] sw_rdata,
    // Flash pins
    output logic [19:0] fl_addr,
    output logic [15:0] fl_dq_out,
    output logic fl_dq_oe,
    input wire logic [15:0] fl_dq_in,
    output logic fl_chip_select_n,
    output logic fl_write_strobe_n,
    output logic fl_output_enable_n,
    output logic fl_byte_mode,
    output logic fl_reset_high_voltage,
    input wire logic fl_ready_busy_n
);
    typedef enum logic [5:0] {
        S_IDLE = 6'h01, S_SEQ = 6'h02, S_POLL = 6'h04,
        S_CHECK = 6'h08, S_RECOVER = 6'h10, S_FINISH = 6'h20
    } fcsm_st_t;

    fcsm_cyc_if cyc ();

    fcsm_st_t st_r, st_nxt;
    logic [2:0] op_r, op_nxt;
    logic [2:0] step_r, step_nxt;
    logic [19:0] addr_r, addr_nxt;
    logic [15:0] data_r, data_nxt;
    logic [15:0] rdata_r, rdata_nxt;
    logic byte_r, byte_nxt;
    logic unprot_r, unprot_nxt;
    logic busy_r, done_r, done_nxt, fail_r, fail_nxt;
    logic req_r, req_nxt;
    logic [16:0] poll_cnt_r, poll_cnt_nxt;
    logic rb_s1_r, rb_s2_r;
    logic [31:0] sw_rdata_r, sw_rdata_nxt;

    // Address/data of one write in a command sequence
    function automatic logic [35:0] seq_word(input logic [2:0] op,
            input logic [2:0] step, input logic bm,
            input logic [19:0] a, input logic [15:0] d);
        logic [19:0] u1;
        logic [19:0] u2;
        u1 = bm ? fcsm_pkg::UNLOCK1_ADDR_B : fcsm_pkg::UNLOCK1_ADDR_W;
        u2 = bm ? fcsm_pkg::UNLOCK2_ADDR_B : fcsm_pkg::UNLOCK2_ADDR_W;
        unique case (step)
            3'h0: seq_word = {u1, fcsm_pkg::CMD_UNLOCK1};
            3'h1: seq_word = {u2, fcsm_pkg::CMD_UNLOCK2};
            3'h2: seq_word = {u1, (op == fcsm_pkg::OP_PROGRAM) ?
                fcsm_pkg::CMD_PROGRAM : (op == fcsm_pkg::OP_AUTOSEL) ?
                fcsm_pkg::CMD_AUTOSEL : fcsm_pkg::CMD_ERASE};
            // Fourth write of a program carries target address and data
            3'h3: seq_word = (op == fcsm_pkg::OP_PROGRAM) ? {a, d}
                : {u1, fcsm_pkg::CMD_UNLOCK1};
            3'h4: seq_word = {u2, fcsm_pkg::CMD_UNLOCK2};
            default: seq_word = {u1, fcsm_pkg::CMD_CHIP_ERASE};
        endcase
    endfunction : seq_word

    // Number of writes in a sequence
    function automatic logic [2:0] seq_len(input logic [2:0] op);
        unique case (op)
            fcsm_pkg::OP_RESET: seq_len = 3'h1;
            fcsm_pkg::OP_AUTOSEL: seq_len = 3'h3;
            fcsm_pkg::OP_PROGRAM: seq_len = 3'h4;
            fcsm_pkg::OP_CHIP_ERASE: seq_len = 3'h6;
            default: seq_len = 3'h0;
        endcase
    endfunction : seq_len

    logic [35:0] word;
    assign word = seq_word(op_r, step_r, byte_r, addr_r, data_r);

    always_comb begin
        st_nxt = st_r;
        op_nxt = op_r;
        step_nxt = step_r;
        addr_nxt = addr_r;
        data_nxt = data_r;
        rdata_nxt = rdata_r;
        byte_nxt = byte_r;
        unprot_nxt = unprot_r;
        done_nxt = done_r;
        fail_nxt = fail_r;
        req_nxt = 1'b0;
        poll_cnt_nxt = poll_cnt_r;
        sw_rdata_nxt = 32'h00000000;
        if (sw_rd) begin
            unique case (sw_addr)
                fcsm_pkg::REG_CTRL: sw_rdata_nxt = 32'({unprot_r, byte_r,
                    op_r, 1'b0});
                fcsm_pkg::REG_ADDR: sw_rdata_nxt = 32'(addr_r);
                fcsm_pkg::REG_DATA: sw_rdata_nxt = 32'(rdata_r);
                fcsm_pkg::REG_STAT: sw_rdata_nxt = 32'({rb_s2_r, fail_r,
                    done_r, busy_r});
                default: sw_rdata_nxt = 32'h00000000;
            endcase
        end
        // Configuration writes are taken only while idle
        if (sw_wr && st_r == S_IDLE) begin
            unique case (sw_addr)
                fcsm_pkg::REG_ADDR: addr_nxt = sw_wdata[19:0];
                fcsm_pkg::REG_DATA: data_nxt = sw_wdata[15:0];
                fcsm_pkg::REG_CTRL: begin
                    byte_nxt = sw_wdata[fcsm_pkg::CTRL_BYTE_BIT];
                    unprot_nxt = sw_wdata[fcsm_pkg::CTRL_UNPROT_BIT];
                    op_nxt = sw_wdata[fcsm_pkg::CTRL_OP_LSB +: 3];
                    if (sw_wdata[fcsm_pkg::CTRL_GO_LSB]) begin
                        done_nxt = 1'b0;
                        fail_nxt = 1'b0;
                        step_nxt = 3'h0;
                        poll_cnt_nxt = 17'h00000;
                        st_nxt = S_SEQ;
                        req_nxt = 1'b1;
                    end
                end
                default: ;
            endcase
        end
        unique case (st_r)
            S_IDLE: ;
            S_SEQ: begin
                if (cyc.done) begin
                    if (step_r == seq_len(op_r)) begin
                        // Final read completes a plain or ID read
                        rdata_nxt = cyc.rdata;
                        st_nxt = S_FINISH;
                    end else if (step_r + 3'h1 == seq_len(op_r) &&
                            (op_r == fcsm_pkg::OP_PROGRAM ||
                             op_r == fcsm_pkg::OP_CHIP_ERASE)) begin
                        st_nxt = S_POLL;
                        req_nxt = 1'b1;
                    end else if (step_r + 3'h1 == seq_len(op_r) &&
                            op_r == fcsm_pkg::OP_RESET) begin
                        st_nxt = S_FINISH;
                    end else begin
                        step_nxt = step_r + 3'h1;
                        req_nxt = 1'b1;
                    end
                end
            end
            S_POLL: begin
                // Only reads while busy; writes would be ignored
                if (cyc.done) begin
                    rdata_nxt = cyc.rdata;
                    poll_cnt_nxt = poll_cnt_r + 17'h00001;
                    st_nxt = S_CHECK;
                end
            end
            S_CHECK: begin
                // Poll flag shows true data bit when complete
                if (op_r == fcsm_pkg::OP_PROGRAM &&
                        rdata_r[fcsm_pkg::ADDR_POLL_BIT] ==
                        data_r[fcsm_pkg::ADDR_POLL_BIT]) begin
                    st_nxt = S_FINISH;
                end else if (op_r == fcsm_pkg::OP_CHIP_ERASE &&
                        rdata_r[fcsm_pkg::ADDR_POLL_BIT]) begin
                    st_nxt = S_FINISH;
                // Timeout flag or no progress: write reset
                end else if (rdata_r[fcsm_pkg::FAIL_FLAG_BIT] ||
                        poll_cnt_r == 17'(fcsm_pkg::POLL_LIMIT)) begin
                    fail_nxt = 1'b1;
                    op_nxt = fcsm_pkg::OP_RESET;
                    step_nxt = 3'h0;
                    st_nxt = S_RECOVER;
                    req_nxt = 1'b1;
                end else begin
                    st_nxt = S_POLL;
                    req_nxt = 1'b1;
                end
            end
            S_RECOVER: begin
                if (cyc.done) begin
                    st_nxt = S_FINISH;
                end
            end
            S_FINISH: begin
                done_nxt = 1'b1;
                st_nxt = S_IDLE;
            end
            default: st_nxt = S_IDLE;
        endcase
    end

    assign busy_r = (st_r != S_IDLE);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= S_IDLE;
            op_r <= fcsm_pkg::OP_READ;
            step_r <= 3'h0;
            addr_r <= 20'h00000;
            data_r <= 16'h0000;
            rdata_r <= 16'h0000;
            byte_r <= 1'b0;
            unprot_r <= 1'b0;
            done_r <= 1'b0;
            fail_r <= 1'b0;
            req_r <= 1'b0;
            poll_cnt_r <= 17'h00000;
            rb_s1_r <= 1'b1;
            rb_s2_r <= 1'b1;
            sw_rdata_r <= 32'h00000000;
        end else begin
            st_r <= st_nxt;
            op_r <= op_nxt;
            step_r <= step_nxt;
            addr_r <= addr_nxt;
            data_r <= data_nxt;
            rdata_r <= rdata_nxt;
            byte_r <= byte_nxt;
            unprot_r <= unprot_nxt;
            done_r <= done_nxt;
            fail_r <= fail_nxt;
            req_r <= req_nxt;
            poll_cnt_r <= poll_cnt_nxt;
            rb_s1_r <= fl_ready_busy_n;
            rb_s2_r <= rb_s1_r;
            sw_rdata_r <= sw_rdata_nxt;
        end
    end

    // Writes for sequence steps and the recovery reset, reads otherwise
    assign cyc.req = req_r;
    assign cyc.wr = (st_r == S_SEQ && step_r < seq_len(op_r)) ||
                    st_r == S_RECOVER;
    assign cyc.addr = (st_r == S_SEQ && step_r < seq_len(op_r)) ?
                      word[35:16] : addr_r;
    assign cyc.wdata = (op_r == fcsm_pkg::OP_RESET) ? fcsm_pkg::CMD_RESET
                       : word[15:0];

    // Cycle engine keeps strobes high out of reset
    fcsm_cycle u_cycle (
        .clk(clk),
        .rst_n(rst_n),
        .cyc(cyc.eng),
        .fl_addr(fl_addr),
        .fl_dq_out(fl_dq_out),
        .fl_dq_oe(fl_dq_oe),
        .fl_dq_in(fl_dq_in),
        .fl_chip_select_n(fl_chip_select_n),
        .fl_write_strobe_n(fl_write_strobe_n),
        .fl_output_enable_n(fl_output_enable_n)
    );

    assign fl_byte_mode = byte_r;
    assign fl_reset_high_voltage = unprot_r;
    assign sw_rdata = sw_rdata_r;
endmodule : fcsm_host
`default_nettype wire

/* File: verification/fcsm_host_sva.sv */
// Pin-level assertions for the flash host controller
`timescale 1ns/1ps
`default_nettype none
module fcsm_host_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Software port
    input wire logic [3:0] sw_addr,
    input wire logic sw_wr,
    // Flash pins
    input wire logic [19:0] fl_addr,
    input wire logic [15:0] fl_dq_out,
    input wire logic fl_dq_oe,
    input wire logic fl_chip_select_n,
    input wire logic fl_write_strobe_n,
    input wire logic fl_output_enable_n,
    input wire logic fl_reset_high_voltage
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Five-cycle write pulse
    sequence s_pulse;
        !fl_write_strobe_n [*5] ##1 fl_write_strobe_n;
    endsequence
    sequence s_start;
        $fell(fl_write_strobe_n);
    endsequence
    AST_WR_QUAL: assert property (
        !fl_write_strobe_n |-> !fl_chip_select_n && fl_output_enable_n)
        else $error("unqualified write strobe");
    AST_RST_QUIET: assert property (
        $rose(rst_n) |-> fl_write_strobe_n && fl_chip_select_n)
        else $error("strobes active after reset");
    AST_ADDR_HOLD: assert property (
        !fl_write_strobe_n && !$past(fl_write_strobe_n)
        |-> $stable(fl_addr) && $stable(fl_dq_out))
        else $error("address or data moved in pulse");
    AST_DATA_HOLD: assert property (
        $rose(fl_write_strobe_n) |-> fl_dq_oe && $stable(fl_dq_out))
        else $error("data dropped at strobe rise");
    AST_PULSE: assert property (
        s_start |-> s_pulse)
        else $error("write pulse length wrong");
    AST_SETUP: assert property (
        s_start |-> !$past(fl_chip_select_n, 2))
        else $error("select setup too short");
    AST_NO_FIGHT: assert property (
        !fl_output_enable_n |-> !fl_dq_oe && fl_write_strobe_n)
        else $error("data driven during read");
    AST_HV_SRC: assert property (
        $changed(fl_reset_high_voltage)
        |-> $past(sw_wr) && $past(sw_addr) == fcsm_pkg::REG_CTRL)
        else $error("unprotect changed without write");
endmodule : fcsm_host_sva
bind fcsm_host fcsm_host_sva fcsm_host_sva_inst (.clk(clk), .rst_n(rst_n),
    .sw_addr(sw_addr), .sw_wr(sw_wr), .fl_addr(fl_addr),
    .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe),
    .fl_chip_select_n(fl_chip_select_n),
    .fl_write_strobe_n(fl_write_strobe_n),
    .fl_output_enable_n(fl_output_enable_n),
    .fl_reset_high_voltage(fl_reset_high_voltage));
`default_nettype wire

/* File: verification/fcsm_flash_model.sv */
// Model of the NOR flash on the far side
`timescale 1ns/1ps
`default_nettype none
module fcsm_flash_model #(
    // Identity values are arbitrary
    parameter logic [15:0] MFR_CODE = 16'h005A,
    parameter logic [15:0] DEV_CODE = 16'h2468,
    parameter logic [15:0] CONT_CODE = 16'h0011,
    parameter int PGM_CYC = 40,
    parameter int ERS_CYC = 200
) (
    // Sampling clock
    input wire logic clk,
    // Flash pins
    input wire logic [19:0] fl_addr,
    input wire logic [15:0] fl_dq_out,
    output logic [15:0] fl_dq_in,
    input wire logic fl_chip_select_n,
    input wire logic fl_write_strobe_n,
    input wire logic fl_output_enable_n,
    input wire logic fl_reset_high_voltage,
    output logic fl_ready_busy_n
);
    logic [15:0] mem [0:255];
    logic [15:0] ld, tgt, last;
    logic [19:0] la;
    logic [2:0] step;
    logic wr, was_wr, rd, was_rd, armed, busy, erase, tout, tog, asel, pgm;
    int cnt;
    // upper half locked unless high voltage on pin
    function automatic logic locked(input logic [19:0] a);
        return a[7] && !fl_reset_high_voltage;
    endfunction : locked
    function automatic logic hit(input logic [19:0] a, input logic [7:0] d);
        return la == a && ld[7:0] == d;
    endfunction : hit
    // write needs select, strobe low, enable high
    assign wr = !fl_chip_select_n && !fl_write_strobe_n && fl_output_enable_n;
    assign rd = !fl_chip_select_n && !fl_output_enable_n;
    assign fl_ready_busy_n = !busy;
    always @* begin
        if (!rd)
            fl_dq_in = ~last;
        else if (busy || tout)
            fl_dq_in = {8'h00, erase ? 1'b0 : ~tgt[7], tog, tout, 5'h00};
        else if (asel)
            case (fl_addr[1:0])
                2'h0: fl_dq_in = MFR_CODE;
                2'h1: fl_dq_in = DEV_CODE;
                2'h3: fl_dq_in = CONT_CODE;
                default: fl_dq_in = {15'h0000, fl_addr[7]};
            endcase
        else
            fl_dq_in = mem[fl_addr[7:0]];
    end
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 16'h3C00 | 16'(i);
        {was_wr, was_rd, armed, busy, erase, tout, tog, asel, pgm} = '0;
        step = 3'h0;
        last = 16'h0000;
    end
    task automatic command();
        if (ld[7:0] == fcsm_pkg::CMD_RESET[7:0]) begin
            step <= 3'h0;
            {asel, pgm, tout} <= 3'h0;
        end else if (pgm) begin
            pgm <= 1'b0;
            {tgt, erase} <= {ld, 1'b0};
            if (locked(la))
                tout <= 1'b1;
            else begin
                mem[la[7:0]] <= mem[la[7:0]] & ld;
                {busy, cnt} <= {1'b1, PGM_CYC};
            end
        end else if (!asel) begin
            step <= 3'h0;
            case (step)
                3'h0, 3'h3: if (hit(fcsm_pkg::UNLOCK1_ADDR_W, 8'hAA))
                    step <= step + 3'h1;
                3'h1, 3'h4: if (hit(fcsm_pkg::UNLOCK2_ADDR_W, 8'h55))
                    step <= step + 3'h1;
                3'h2: begin
                    asel <= hit(fcsm_pkg::UNLOCK1_ADDR_W, 8'h90);
                    pgm <= hit(fcsm_pkg::UNLOCK1_ADDR_W, 8'hA0);
                    if (hit(fcsm_pkg::UNLOCK1_ADDR_W, 8'h80)) step <= 3'h3;
                end
                3'h5: if (hit(fcsm_pkg::UNLOCK1_ADDR_W, 8'h10))
                    {erase, busy, cnt} <= {2'h3, ERS_CYC};
                default: step <= 3'h0;
            endcase
        end
    endtask : command
    always @(posedge clk) begin
        was_wr <= wr;
        was_rd <= rd;
        if (rd) last <= fl_dq_in;
        if (was_rd && !rd) tog <= !tog;
        // strobe low at power-up not taken
        if (!wr) armed <= 1'b1;
        // address at write start, data at end
        if (wr && !was_wr) la <= fl_addr;
        if (wr) ld <= fl_dq_out;
        if (busy) begin
            cnt <= cnt - 1;
            if (cnt == 1) begin
                busy <= 1'b0;
                if (erase)
                    for (int i = 0; i < 256; i++)
                        if (!locked(20'(i))) mem[i] <= 16'hFFFF;
            end
        end else if (was_wr && !wr && armed) command();
    end
endmodule : fcsm_flash_model
`default_nettype wire

/* File: verification/tb_fcsm_host.sv */
// Self-checking testbench for the flash host controller
`timescale 1ns/1ps
`default_nettype none
module tb_fcsm_host;
    // Arbitrary identity values
    localparam logic [15:0] MFR = 16'h005A;
    localparam logic [15:0] DEV = 16'h2468;
    localparam logic [15:0] CONT = 16'h0011;
    logic clk, rst_n, sw_wr, sw_rd;
    logic [3:0] sw_addr;
    logic [31:0] sw_wdata, sw_rdata;
    logic [19:0] fl_addr;
    logic [15:0] fl_dq_out, fl_dq_in;
    logic fl_dq_oe, fl_chip_select_n, fl_write_strobe_n, fl_output_enable_n;
    logic fl_byte_mode, fl_reset_high_voltage, fl_ready_busy_n;
    int n_mismatch, checks;
    fcsm_host fcsm_host_inst (.clk(clk), .rst_n(rst_n), .sw_addr(sw_addr),
        .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
        .sw_rdata(sw_rdata), .fl_addr(fl_addr), .fl_dq_out(fl_dq_out),
        .fl_dq_oe(fl_dq_oe), .fl_dq_in(fl_dq_in),
        .fl_chip_select_n(fl_chip_select_n),
        .fl_write_strobe_n(fl_write_strobe_n),
        .fl_output_enable_n(fl_output_enable_n),
        .fl_byte_mode(fl_byte_mode),
        .fl_reset_high_voltage(fl_reset_high_voltage),
        .fl_ready_busy_n(fl_ready_busy_n));
    fcsm_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV), .CONT_CODE(CONT))
    fcsm_flash_model_inst (.clk(clk), .fl_addr(fl_addr),
        .fl_dq_out(fl_dq_out), .fl_dq_in(fl_dq_in),
        .fl_chip_select_n(fl_chip_select_n),
        .fl_write_strobe_n(fl_write_strobe_n),
        .fl_output_enable_n(fl_output_enable_n),
        .fl_reset_high_voltage(fl_reset_high_voltage),
        .fl_ready_busy_n(fl_ready_busy_n));
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done
    task automatic chk(input string nm, input logic [31:0] e, g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic sw_write(input logic [3:0] a, input logic [31:0] d);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge clk);
        sw_wr <= 1'b0;
        @(posedge clk);
    endtask : sw_write
    task automatic sw_read(input logic [3:0] a, output logic [31:0] d);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge clk);
        sw_rd <= 1'b0;
        #1 d = sw_rdata;
        @(posedge clk);
    endtask : sw_read
    task automatic run_op(input logic [2:0] op, input logic [19:0] a,
                          input logic [15:0] d, input logic unp,
                          output logic [31:0] st);
        sw_write(fcsm_pkg::REG_ADDR, {12'h000, a});
        sw_write(fcsm_pkg::REG_DATA, {16'h0000, d});
        sw_write(fcsm_pkg::REG_CTRL, {26'h0, unp, 1'b0, op, 1'b1});
        do begin
            sw_read(fcsm_pkg::REG_STAT, st);
        end while (st[0] !== 1'b0);
    endtask : run_op
    task automatic rd_arr(input logic [19:0] a, output logic [31:0] v);
        logic [31:0] st;
        run_op(fcsm_pkg::OP_READ, a, 16'h0000, 1'b0, st);
        sw_read(fcsm_pkg::REG_DATA, v);
    endtask : rd_arr
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #500000;
        n_mismatch++;
        test_done();
    end
    initial begin
        logic [31:0] v, st;
        logic [19:0] as_a [0:4];
        logic [15:0] as_e [0:4];
        as_a = '{20'h00000, 20'h00001, 20'h00003, 20'h00002, 20'h00082};
        as_e = '{MFR, DEV, CONT, 16'h0000, 16'h0001};
        {rst_n, sw_wr, sw_rd, sw_addr, sw_wdata} = '0;
        {n_mismatch, checks} = '0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        sw_read(fcsm_pkg::REG_STAT, v);
        chk("reset stat", 32'h8, v);
        sw_read(4'h2, v);
        chk("unmapped", 32'h0, v);
        sw_write(fcsm_pkg::REG_CTRL, 32'h10);
        chk("byte pin", 32'h1, 32'(fl_byte_mode));
        rd_arr(20'h00012, v);
        chk("power-up read", 32'h3C12, v);
        $display("test power-up read done");
        for (int i = 0; i < 5; i++) begin
            run_op(fcsm_pkg::OP_AUTOSEL, as_a[i], 16'h0000, 1'b0, st);
            sw_read(fcsm_pkg::REG_DATA, v);
            chk("id code", {16'h0, as_e[i]}, v);
        end
        rd_arr(20'h00013, v);
        chk("id held", {16'h0, CONT}, v);
        run_op(fcsm_pkg::OP_RESET, 20'h00000, 16'h0000, 1'b0, st);
        rd_arr(20'h00013, v);
        chk("after reset", 32'h3C13, v);
        $display("test autoselect done");
        run_op(fcsm_pkg::OP_CHIP_ERASE, 20'h00000, 16'h0000, 1'b0, st);
        chk("erase stat", 32'hA, st);
        rd_arr(20'h00020, v);
        chk("erased word", 32'hFFFF, v);
        rd_arr(20'h00090, v);
        chk("locked kept", 32'h3C90, v);
        $display("test chip erase done");
        run_op(fcsm_pkg::OP_PROGRAM, 20'h00020, 16'h12B4, 1'b0, st);
        chk("prog stat", 32'hA, st);
        rd_arr(20'h00020, v);
        chk("prog word", 32'h12B4, v);
        run_op(fcsm_pkg::OP_PROGRAM, 20'h00020, 16'hFFFF, 1'b0, st);
        rd_arr(20'h00020, v);
        chk("zero bits kept", 32'h12B4, v);
        $display("test program done");
        run_op(fcsm_pkg::OP_PROGRAM, 20'h00090, 16'h00B4, 1'b0, st);
        chk("locked refused", 32'hE, st);
        rd_arr(20'h00090, v);
        chk("locked word", 32'h3C90, v);
        run_op(fcsm_pkg::OP_PROGRAM, 20'h00090, 16'h00B4, 1'b1, st);
        chk("unlock stat", 32'hA, st);
        rd_arr(20'h00090, v);
        chk("unlock word", 32'h0090, v);
        run_op(fcsm_pkg::OP_PROGRAM, 20'h00091, 16'h0000, 1'b0, st);
        chk("relocked", 32'hE, st);
        $display("test sector protection done");
        test_done();
    end
endmodule : tb_fcsm_host
`default_nettype wire
